// ### core/tsc_async0_top.sv
// Async mode 0 timestamp controller: counts oscillator periods around each in-band interrupt.
`timescale 1ns/100ps
`default_nettype none
module tsc_async0_top #(
  parameter int COUNT_W = 16  // Width of the oscillator period counters.
) (
  // Clock and reset.
  input  wire logic               sys_clk,
  input  wire logic               reset_n,
  // Asynchronous pins: internal oscillator and I3C clock.
  input  wire logic               osc_clk,
  input  wire logic               scl_in,
  // Events from the sensor core and the I3C transport, same clock.
  input  wire logic               drdy,
  input  wire logic               ibi_ack,
  input  wire logic               ccc_valid,
  input  wire logic [7:0]         ccc_code,
  input  wire logic [7:0]         ccc_sub,
  // Interrupt request and timing values.
  output logic                    ibi_req,
  output logic                    ibi_en,
  output logic                    async0_on,
  output logic [COUNT_W-1:0]      sc1,
  output logic [COUNT_W-1:0]      sc2,
  output logic                    ts_valid,
  // Answer to the timing capability query.
  output logic                    xt_valid,
  output logic [7:0]              xt_modes,
  output logic [7:0]              xt_state,
  output logic [7:0]              xt_freq,
  output logic [7:0]              xt_accuracy
);
  import tsc_pkg::*;

  localparam logic [COUNT_W-1:0] CNT_MAX = '1;  // Counter saturates here.
  localparam logic [COUNT_W-1:0] CNT_ONE = COUNT_W'(1);
  localparam logic [3:0]         EDGE_ONE = 4'h1;

  // All state of the controller.
  typedef struct packed {
    tsc_state_t         st;        // Sequencer state.
    logic [COUNT_W-1:0] cnt;       // Running oscillator period count.
    logic [3:0]         scl_cnt;   // SCL rises since the acknowledge.
    logic [COUNT_W-1:0] sc1;       // Data ready to acknowledge.
    logic [COUNT_W-1:0] sc2;       // Acknowledge to T bit.
    logic               ibi_req;   // Pending in-band interrupt request.
    logic               ts_valid;  // Pulse when both values are fresh.
    logic               async0;    // Async mode zero active.
    logic               ibi_en;    // In-band interrupts enabled.
    logic               xt_valid;  // Pulse with the capability answer.
    logic [7:0]         xt_state;  // Current mode byte of the answer.
  } tsc_state_s_t;

  tsc_state_s_t r_q;  // Registered state.
  tsc_state_s_t r_d;  // Next state.

  tsc_edge_if osc_e ();  // Oscillator edges.
  tsc_edge_if scl_e ();  // SCL edges.

  // Oscillator pin synchroniser; at 250 MHz each 4.32 MHz period spans
  // dozens of samples, so no edge is missed.
  tsc_edge_sync u_osc_sync (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .pin     (osc_clk),
    .edge_o  (osc_e)
  );

  // SCL pin synchroniser; the three-stage delay is the same for every
  // edge, so counting rises is not disturbed by it.
  tsc_edge_sync u_scl_sync (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .pin     (scl_in),
    .edge_o  (scl_e)
  );

  logic set_cmd;    // A set-time command was received.
  logic get_cmd;    // A capability query was received.
  logic drdy_evt;   // Data ready that starts a new measurement.

  // Decode of the common commands.
  always_comb begin
    set_cmd  = ccc_valid && ((ccc_code == TSC_CCC_SETXTIME_B) ||
                             (ccc_code == TSC_CCC_SETXTIME_D));
    get_cmd  = ccc_valid && (ccc_code == TSC_CCC_GETXTIME);
    drdy_evt = drdy && r_q.async0 && r_q.ibi_en;
  end

  // Mode control, capability answer and the measurement sequencer.
  always_comb begin
    r_d          = r_q;
    r_d.ts_valid = 1'b0;
    r_d.xt_valid = 1'b0;
    // Entering async mode zero also enables interrupts, no separate setup.
    if (set_cmd && (ccc_sub == TSC_SUB_ENTER_ASYNC0)) begin
      r_d.async0   = 1'b1;
      r_d.ibi_en   = 1'b1;
      r_d.xt_state = TSC_XT_STATE_ASY0;
    end else if (set_cmd && (ccc_sub == TSC_SUB_EXIT)) begin
      r_d.async0   = 1'b0;
      r_d.ibi_en   = 1'b0;
      r_d.xt_state = TSC_XT_STATE_NONE;
    end
    // The fixed fields come straight from constants; only the pulse is stored.
    if (get_cmd) begin
      r_d.xt_valid = 1'b1;
    end
    // Free counting of oscillator rises while a measurement runs.
    if ((r_q.st != TSC_IDLE) && osc_e.rise && (r_q.cnt != CNT_MAX)) begin
      r_d.cnt = r_q.cnt + CNT_ONE;
    end
    unique case (r_q.st)
      TSC_IDLE: begin
        r_d.ibi_req = 1'b0;
      end
      TSC_WAIT_ACK: begin
        // The first value closes at the acknowledge; the second starts there.
        if (ibi_ack) begin
          r_d.sc1     = r_q.cnt;
          r_d.cnt     = '0;
          r_d.scl_cnt = '0;
          r_d.ibi_req = 1'b0;
          r_d.st      = TSC_WAIT_TBIT;
        end
      end
      TSC_WAIT_TBIT: begin
        // A stalled SCL simply stretches this wait and raises the count.
        if (scl_e.rise) begin
          r_d.scl_cnt = r_q.scl_cnt + EDGE_ONE;
          if (r_q.scl_cnt + EDGE_ONE == TSC_TBIT_SCL_EDGE) begin
            r_d.sc2      = r_q.cnt;
            r_d.ts_valid = 1'b1;
            r_d.st       = TSC_IDLE;
          end
        end
      end
    endcase
    // Leaving the mode abandons any measurement in progress.
    if (!r_d.async0) begin
      r_d.st      = TSC_IDLE;
      r_d.ibi_req = 1'b0;
    end
    // A new data ready wins unless the mode is left in the same cycle, and restarts the first count, so the
    // controller never sees a value measured from a stale sample.
    if (drdy_evt && r_d.async0) begin
      r_d.st       = TSC_WAIT_ACK;
      r_d.cnt      = '0;
      r_d.ibi_req  = 1'b1;
      r_d.ts_valid = 1'b0;
    end
  end

  // Synchronous active-low reset; mode off, nothing pending.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      r_q          <= '0;
      r_q.st       <= TSC_IDLE;
      r_q.xt_state <= TSC_XT_STATE_NONE;
    end else begin
      r_q <= r_d;
    end
  end

  // Outputs straight from the state register; the fixed answer fields come from constants.
  assign ibi_req     = r_q.ibi_req;
  assign ibi_en      = r_q.ibi_en;
  assign async0_on   = r_q.async0;
  assign sc1         = r_q.sc1;
  assign sc2         = r_q.sc2;
  assign ts_valid    = r_q.ts_valid;
  assign xt_valid    = r_q.xt_valid;
  assign xt_state    = r_q.xt_state;
  assign xt_modes    = TSC_XT_MODES;
  assign xt_freq     = TSC_XT_FREQ;
  assign xt_accuracy = TSC_XT_ACCURACY;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // Acknowledge taken while waiting, with no restart in the same cycle.
  sequence s_ack_taken;
    (r_q.st == TSC_WAIT_ACK) && ibi_ack && !drdy_evt && !set_cmd;
  endsequence

  // Ninth SCL rise after the acknowledge, with no restart.
  sequence s_tbit_seen;
    (r_q.st == TSC_WAIT_TBIT) && scl_e.rise &&
    (r_q.scl_cnt + EDGE_ONE == TSC_TBIT_SCL_EDGE) && !drdy && !set_cmd;
  endsequence

  a_enter_async0: assert property (
    set_cmd && (ccc_sub == TSC_SUB_ENTER_ASYNC0) |=> async0_on && (xt_state == TSC_XT_STATE_ASY0))
    else $error("Enter sub-command did not start async mode zero.");

  a_ibi_self_enable: assert property (
    $rose(async0_on) |-> ibi_en)
    else $error("Interrupts not enabled on mode entry.");

  a_getx_answer: assert property (
    get_cmd |=> xt_valid && (xt_freq == TSC_XT_FREQ) && (xt_modes == TSC_XT_MODES))
    else $error("Capability query not answered.");

  a_req_on_drdy: assert property (
    drdy && async0_on && ibi_en && !set_cmd |=> ibi_req && (r_q.cnt == '0))
    else $error("Data ready did not raise a request and restart.");

  a_req_only_async0: assert property (
    $rose(ibi_req) |-> $past(async0_on))
    else $error("Request raised outside async mode zero.");

  a_sc1_capture: assert property (
    s_ack_taken |=> (sc1 == $past(r_q.cnt)) && !ibi_req && (r_q.cnt == '0))
    else $error("First value not captured at acknowledge.");

  a_sc2_capture: assert property (
    s_tbit_seen |=> ts_valid && (sc2 == $past(r_q.cnt)) ##1 !ts_valid)
    else $error("Second value not captured at T bit.");

  a_osc_counting: assert property (
    (r_q.st != TSC_IDLE) && osc_e.rise && (r_q.cnt != CNT_MAX) && !drdy && !ibi_ack &&
    !set_cmd |=> r_q.cnt == $past(r_q.cnt) + CNT_ONE)
    else $error("Oscillator rise not counted.");

  a_value_with_ibi: assert property (
    $rose(ts_valid) |-> $past(r_q.st) == TSC_WAIT_TBIT)
    else $error("Timing values reported without an interrupt.");

endmodule
`default_nettype wire

// ### core/tsc_pkg.sv
// Constants, command codes and state types of the async mode 0 timestamp controller.
// Summary of operation
// - Support timing-control asynchronous mode zero only; the GETXTIME modes answer 0x03 also reports sync mode.
// - Count periods of the 4.32MHz oscillator.
// - First count runs from data ready to acknowledge.
// - Second count runs from acknowledge to T bit.
// - Answer GETXTIME with accuracy, frequency, supported modes.
// - SETXTIME sub-command 0xdf enters async mode zero.
// - Timing values travel with in-band interrupts.
// - Entering async mode zero enables interrupts itself.
package tsc_pkg;

  // Common command codes seen from the transport.
  localparam logic [7:0] TSC_CCC_GETXTIME  = 8'h99;
  localparam logic [7:0] TSC_CCC_SETXTIME_B = 8'h28;
  localparam logic [7:0] TSC_CCC_SETXTIME_D = 8'h98;

  // Sub-commands of the set command.
  localparam logic [7:0] TSC_SUB_ENTER_ASYNC0 = 8'hdf;
  localparam logic [7:0] TSC_SUB_EXIT         = 8'hff;

  // Oscillator figures; frequency is reported in whole 500 kHz units.
  localparam int         TSC_OSC_FREQ_KHZ  = 4320;
  localparam int         TSC_FREQ_UNIT_KHZ = 500;
  localparam logic [7:0] TSC_XT_FREQ       = 8'(TSC_OSC_FREQ_KHZ / TSC_FREQ_UNIT_KHZ);

  // Accuracy in units of 0.1 percent, here 5 percent.
  localparam logic [7:0] TSC_XT_ACCURACY = 8'h32;

  // Supported mode bits: bit 0 sync mode, bit 1 async mode zero.
  localparam logic [7:0] TSC_XT_MODES      = 8'h03;
  localparam logic [7:0] TSC_XT_STATE_ASY0 = 8'h02;
  localparam logic [7:0] TSC_XT_STATE_NONE = 8'h00;

  // Eight data bits after the acknowledge, then the T bit on the ninth SCL rise.
  localparam logic [3:0] TSC_TBIT_SCL_EDGE = 4'h9;

  // Clocks after reset until all three synchroniser stages hold the pin.
  localparam logic [1:0] TSC_SYNC_FILL = 2'h3;

  // Sequencer states of the timestamp counter.
  typedef enum logic [1:0] {
    TSC_IDLE,
    TSC_WAIT_ACK,
    TSC_WAIT_TBIT
  } tsc_state_t;

endpackage

// ### core/tsc_edge_if.sv
// Interface carrying a synchronised level and its edge pulses.
`timescale 1ns/100ps
`default_nettype none
interface tsc_edge_if;
  logic level;  // Filtered level of the pin.
  logic rise;   // One-cycle pulse on a filtered rising edge.
  logic fall;   // One-cycle pulse on a filtered falling edge.
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface
`default_nettype wire

// ### core/tsc_edge_sync.sv
// Three-stage pin synchroniser with agreement filter and edge pulses.
`timescale 1ns/100ps
`default_nettype none
module tsc_edge_sync (
  // Clock and reset.
  input  wire logic sys_clk,
  input  wire logic reset_n,
  // Asynchronous pin.
  input  wire logic pin,
  // Filtered result.
  tsc_edge_if.src   edge_o
);
  import tsc_pkg::*;

  // All state of the synchroniser.
  typedef struct packed {
    logic s1;    // First stage, read only by the second.
    logic s2;    // Second stage.
    logic s3;    // Third stage.
    logic lvl;   // Accepted level.
    logic rise;  // Rising pulse.
    logic fall;  // Falling pulse.
    logic [1:0] fill;  // Clocks since reset, until the stages are full.
  } tsc_sync_t;

  tsc_sync_t r_q;  // Registered state.
  tsc_sync_t r_d;  // Next state.

  // A change is accepted only once the second and third stages agree, so one
  // metastable sample cannot produce a false edge.
  always_comb begin
    r_d      = r_q;
    r_d.s1   = pin;
    r_d.s2   = r_q.s1;
    r_d.s3   = r_q.s2;
    r_d.rise = 1'b0;
    r_d.fall = 1'b0;
    if (r_q.fill != TSC_SYNC_FILL) begin
      // Until the stages are full the accepted level follows them silently,
      // so a pin that idles high gives no false rising edge after reset.
      r_d.fill = r_q.fill + 2'h1;
      r_d.lvl  = r_q.s2;
    end else if ((r_q.s2 == r_q.s3) && (r_q.s3 != r_q.lvl)) begin
      r_d.lvl  = r_q.s3;
      r_d.rise = r_q.s3;
      r_d.fall = ~r_q.s3;
    end
  end

  // Synchronous reset to all zero.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign edge_o.level = r_q.lvl;
  assign edge_o.rise  = r_q.rise;
  assign edge_o.fall  = r_q.fall;

endmodule
`default_nettype wire

// ### dv/tsc_ctrl_model.sv
// Bus controller model: acknowledges interrupts and clocks the mandatory byte on SCL.
`timescale 1ns/100ps
`default_nettype none
module tsc_ctrl_model (
  // Clock of the device side.
  input  wire logic sys_clk,
  // Request from the device, pacing from the bench.
  input  wire logic ibi_req,
  input  var  int   ack_dly,
  input  wire logic stall,
  // Acknowledge pulse and the SCL line.
  output var  logic ibi_ack,
  output var  logic scl_in
);
  // SCL idles high on its pull-up and stands still outside the byte.
  initial begin
    ibi_ack = 1'b0;
    scl_in  = 1'b1;
    forever begin
      @(negedge sys_clk iff ibi_req === 1'b1);
      repeat (ack_dly) @(negedge sys_clk);
      ibi_ack = 1'b1;
      @(negedge sys_clk);
      ibi_ack = 1'b0;
      // Eight data bits, then the T bit on the ninth rise.
      repeat (9) begin
        scl_in = 1'b0;
        // A stretched low phase costs bandwidth, so only some bytes use it.
        #(stall ? 800 : 80);
        scl_in = 1'b1;
        #80;
      end
    end
  end
endmodule
`default_nettype wire

// ### dv/tsc_async0_top_tb_top.sv
// Self-checking bench of the async mode 0 timestamp controller.
`timescale 1ns/100ps
`default_nettype none
module tsc_async0_top_tb_top;
  import tsc_pkg::*;
  logic        sys_clk, reset_n, osc_clk, drdy, ccc_valid, stall, ibi_ack, scl_in;
  logic        ibi_req, ibi_en, async0_on, ts_valid, xt_valid;
  logic [7:0]  ccc_code, ccc_sub, xt_modes, xt_state, xt_freq, xt_accuracy;
  logic [15:0] sc1, sc2;
  int          ack_dly, fail_count, num_checks;
  int          osc_n = 0;  // Oscillator rises seen by the bench.

  tsc_async0_top #(.COUNT_W(16)) tsc_async0_top_inst (
    .sys_clk(sys_clk), .reset_n(reset_n), .osc_clk(osc_clk), .scl_in(scl_in),
    .drdy(drdy), .ibi_ack(ibi_ack), .ccc_valid(ccc_valid), .ccc_code(ccc_code),
    .ccc_sub(ccc_sub), .ibi_req(ibi_req), .ibi_en(ibi_en), .async0_on(async0_on),
    .sc1(sc1), .sc2(sc2), .ts_valid(ts_valid), .xt_valid(xt_valid),
    .xt_modes(xt_modes), .xt_state(xt_state), .xt_freq(xt_freq),
    .xt_accuracy(xt_accuracy));

  tsc_ctrl_model tsc_ctrl_model_inst (
    .sys_clk(sys_clk), .ibi_req(ibi_req), .ack_dly(ack_dly), .stall(stall),
    .ibi_ack(ibi_ack), .scl_in(scl_in));

  // 250 MHz system clock and an unrelated 4.32 MHz oscillator.
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial begin
    osc_clk = 1'b0;
    forever #115.7 osc_clk = ~osc_clk;
  end
  always @(posedge osc_clk) osc_n++;

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk_bit(logic got, logic exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_byte(logic [7:0] got, logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Expected count: oscillator rises between two sampling points of the bench.
  function automatic int osc_span(int from_n, int to_n);
    return to_n - from_n;
  endfunction
  // The oscillator is unrelated in phase, so one period of slip is allowed.
  task automatic chk_cnt(logic [15:0] got, int exp);
    num_checks++;
    if (got !== 16'(exp) && got !== 16'(exp + 1) && got !== 16'(exp - 1)) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One command, taken at the edge between two falling edges.
  task automatic ccc(logic [7:0] code, logic [7:0] sub);
    @(negedge sys_clk);
    ccc_valid = 1'b1;
    ccc_code  = code;
    ccc_sub   = sub;
    @(negedge sys_clk);
    ccc_valid = 1'b0;
  endtask
  task automatic pulse_drdy(output int n);
    @(negedge sys_clk);
    drdy = 1'b1;
    @(posedge sys_clk);
    n = osc_n;
    @(negedge sys_clk);
    drdy = 1'b0;
  endtask

  // One measurement; redo restarts it with a second data ready before the ack.
  task automatic measure(int dly, logic st, logic redo);
    int n0, n1, n2, k;
    ack_dly = dly;
    stall   = st;
    pulse_drdy(n0);
    chk_bit(ibi_req, 1'b1);
    if (redo) begin
      repeat (3) @(negedge sys_clk);
      pulse_drdy(n0);
    end
    k = 0;
    do @(posedge sys_clk); while (ibi_ack !== 1'b1 && k++ < 2000);
    n1 = osc_n;
    @(negedge sys_clk);
    chk_bit(ibi_req, 1'b0);
    chk_cnt(sc1, osc_span(n0, n1));
    repeat (9) @(posedge scl_in);
    n2 = osc_n;
    k  = 0;
    do @(negedge sys_clk); while (ts_valid !== 1'b1 && k++ < 20);
    chk_cnt(sc2, osc_span(n1, n2));
    @(negedge sys_clk);
    chk_bit(ts_valid, 1'b0);
  endtask

  // Eight measurements of at most about 10 us each, plus commands; a generous
  // limit that still stays well under the cycle budget of the run.
  initial begin
    #200000;
    fail_count++;
    tally_and_finish();
  end

  initial begin
    int n;
    logic [7:0] codes [2];
    codes = '{TSC_CCC_SETXTIME_B, TSC_CCC_SETXTIME_D};
    n = $urandom(88);
    reset_n = 1'b0;
    drdy = 1'b0;
    ccc_valid = 1'b0;
    ccc_code = 8'h00;
    ccc_sub = 8'h00;
    stall = 1'b0;
    ack_dly = 8;
    repeat (20) @(negedge sys_clk);
    chk_bit(async0_on | ibi_en | ibi_req | ts_valid, 1'b0);
    reset_n = 1'b1;
    // Data ready outside the mode raises nothing.
    pulse_drdy(n);
    chk_bit(ibi_req, 1'b0);
    ccc(TSC_CCC_GETXTIME, 8'h00);
    chk_bit(xt_valid, 1'b1);
    chk_byte(xt_modes, 8'h03);
    chk_byte(xt_freq, 8'(4320 / 500));
    chk_byte(xt_accuracy, 8'h32);
    @(negedge sys_clk);
    chk_bit(xt_valid, 1'b0);
    // A foreign code carrying the enter sub-command is ignored.
    ccc(8'h55, TSC_SUB_ENTER_ASYNC0);
    chk_bit(async0_on, 1'b0);
    foreach (codes[i]) begin
      ccc(codes[i], TSC_SUB_ENTER_ASYNC0);
      chk_bit(async0_on & ibi_en, 1'b1);
      chk_byte(xt_state, TSC_XT_STATE_ASY0);
      measure($urandom_range(10, 400), 1'b0, 1'b0);
      ccc(codes[i], TSC_SUB_EXIT);
      chk_bit(async0_on, 1'b0);
      chk_byte(xt_state, TSC_XT_STATE_NONE);
      pulse_drdy(n);
      chk_bit(ibi_req, 1'b0);
    end
    ccc(TSC_CCC_SETXTIME_B, TSC_SUB_ENTER_ASYNC0);
    for (int i = 0; i < 6; i++) begin
      measure($urandom_range(10, 400), ($urandom_range(0, 2) == 0), (i == 2));
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
